//--- rtl/pvrb_register_bank.sv
/*
  Vendor register bank: general I/O pins, serial memory command staging,
  state readback and I/O select window decode.
  Assumes the controller supplies decoded index/data port strobes, the
  configuration state, I/O base addresses and reset-time memory bytes, and
  that the serial engine answers each command with a done pulse.
*/
`timescale 1ns/1ns
module pvrb_register_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_index,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire pvrb_pkg::pvrb_cfg_state_e cfg_state,
  input wire logic [3:0] general_io_pins_level,
  output logic [3:0] general_io_pins_data,
  output logic [3:0] general_io_pins_oe,
  output pvrb_pkg::pvrb_nv_cmd_s nv_cmd,
  input wire logic nv_cmd_done,
  output logic nv_busy,
  input wire pvrb_pkg::pvrb_nv_load_s nv_load,
  input wire logic io_valid,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_base_zero,
  input wire logic [15:0] io_base_one,
  output logic io_select_zero,
  output logic io_select_one
);
  logic [3:0] pin_data;
  logic [3:0] pin_direction;
  logic enable_select;
  logic [7:0] word_low;
  logic [7:0] word_high;
  logic [1:0] window_zero;
  logic [1:0] window_one;
  logic wr_cmd;
  logic cmd_accept;
  logic [7:0] next_rd_data;

  // ------------------------------------------------------------
  // General I/O pins
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_data <= pvrb_pkg::reset_nibble;
    end else if (wr_strobe && reg_index == pvrb_pkg::idx_pin_data) begin
      pin_data <= wr_data[3:0]; // [R1] [R17]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_direction <= pvrb_pkg::reset_nibble;
    end else if (wr_strobe && reg_index == pvrb_pkg::idx_pin_direction) begin
      pin_direction <= wr_data[3:0]; // [R5]
    end
  end

  // Data latch is kept for input pins so a later direction flip drives it
  assign general_io_pins_data = pin_data; // [R1]
  assign general_io_pins_oe = pin_direction; // [R2] [R5]

  // ------------------------------------------------------------
  // Serial memory staging
  // ------------------------------------------------------------
  // Select bit only reaches the memory when the next 0x00 command is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_select <= 1'b0;
    end else if (wr_strobe && reg_index == pvrb_pkg::idx_write_enable_select) begin
      enable_select <= wr_data[0]; // [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      word_low <= pvrb_pkg::reset_byte;
    end else if (wr_strobe && reg_index == pvrb_pkg::idx_word_low) begin
      word_low <= wr_data; // [R8]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      word_high <= pvrb_pkg::reset_byte;
    end else if (wr_strobe && reg_index == pvrb_pkg::idx_word_high) begin
      word_high <= wr_data; // [R9]
    end
  end

  assign wr_cmd = wr_strobe && reg_index == pvrb_pkg::idx_command_trigger;
  assign cmd_accept = wr_cmd && !nv_cmd.valid;

  // Command is captured once and held until the engine reports done;
  // the memory itself keeps its protection state between commands.
  always_ff @(posedge clk) begin
    if (reset) begin
      nv_cmd <= '0;
    end else if (nv_cmd.valid) begin
      if (nv_cmd_done) begin
        nv_cmd.valid <= 1'b0;
      end
    end else if (wr_cmd && wr_data == pvrb_pkg::cmd_enable_disable) begin
      nv_cmd.valid <= 1'b1; // [R11] [R7] [R13]
      nv_cmd.is_write <= 1'b0;
      nv_cmd.enable <= enable_select;
    end else if (wr_cmd && wr_data == pvrb_pkg::cmd_write_word) begin
      nv_cmd.valid <= 1'b1; // [R12] [R14]
      nv_cmd.is_write <= 1'b1;
      nv_cmd.word <= {word_high, word_low};
    end
  end

  assign nv_busy = nv_cmd.valid; // [R19]

  // ------------------------------------------------------------
  // Window sizes, internal only
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      window_zero <= pvrb_pkg::reset_window;
      window_one <= pvrb_pkg::reset_window;
    end else if (nv_load.load) begin
      if (nv_load.addr == pvrb_pkg::nv_addr_window_zero) begin
        window_zero <= nv_load.data[1:0]; // [R16]
      end
      if (nv_load.addr == pvrb_pkg::nv_addr_window_one) begin
        window_one <= nv_load.data[1:0]; // [R16]
      end
    end
  end

  // Window of 2^(4+code) bytes: mask drops the low 4..7 address bits
  function automatic logic in_window(input logic [15:0] a, input logic [15:0] b,
                                     input logic [1:0] code);
    logic [15:0] mask;
    mask = 16'hffff << (pvrb_pkg::base_window_bits + int'(code)); // [R15]
    return (a & mask) == (b & mask);
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      io_select_zero <= 1'b0;
      io_select_one <= 1'b0;
    end else begin
      io_select_zero <= io_valid && in_window(io_addr, io_base_zero, window_zero); // [R18]
      io_select_one <= io_valid && in_window(io_addr, io_base_one, window_one); // [R18]
    end
  end

  // ------------------------------------------------------------
  // Read data port
  // ------------------------------------------------------------
  // Write-only and unmapped indices read as zero, so a staged byte
  // never leaks back to the host
  always_comb begin
    next_rd_data = pvrb_pkg::reset_byte;
    case (reg_index)
      pvrb_pkg::idx_pin_data: begin
        next_rd_data = {4'h0, general_io_pins_level}; // [R3] [R4]
      end
      pvrb_pkg::idx_pin_direction: begin
        next_rd_data = {4'h0, pin_direction}; // [R4]
      end
      pvrb_pkg::idx_state_readback: begin
        next_rd_data = {4'h0, cfg_state}; // [R10] [R4]
      end
      default: begin
        next_rd_data = pvrb_pkg::reset_byte;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= pvrb_pkg::reset_byte;
    end else begin
      rd_data <= next_rd_data; // [R17]
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Command handshake in steps: taken when idle, held while busy, dropped on done
  sequence cmd_enable_seq;
    cmd_accept && wr_data == pvrb_pkg::cmd_enable_disable;
  endsequence

  sequence cmd_write_seq;
    cmd_accept && wr_data == pvrb_pkg::cmd_write_word;
  endsequence

  sequence cmd_refused_seq;
    wr_cmd && nv_cmd.valid;
  endsequence

  sequence cmd_held_seq;
    nv_cmd.valid && !nv_cmd_done;
  endsequence

  sequence cmd_done_seq;
    nv_cmd.valid && nv_cmd_done;
  endsequence

  sequence cmd_idle_seq;
    !nv_cmd.valid && !wr_cmd;
  endsequence

  // Pin data and direction
  pin_drive_a: assert property (@(posedge clk) disable iff (reset) // [R1]
    wr_strobe && reg_index == pvrb_pkg::idx_pin_data |=>
    general_io_pins_data == $past(wr_data[3:0]))
    else $error("pin data not driven");
  pin_hold_a: assert property (@(posedge clk) disable iff (reset) // [R1]
    !(wr_strobe && reg_index == pvrb_pkg::idx_pin_data) |=>
    $stable(general_io_pins_data))
    else $error("pin data changed without a write");
  pin_enable_a: assert property (@(posedge clk) disable iff (reset) // [R2]
    wr_strobe && reg_index == pvrb_pkg::idx_pin_data |=>
    $stable(general_io_pins_oe))
    else $error("pin data write changed an enable");
  pin_read_a: assert property (@(posedge clk) disable iff (reset) // [R3]
    reg_index == pvrb_pkg::idx_pin_data |=>
    rd_data == {4'h0, $past(general_io_pins_level)})
    else $error("pin read wrong");
  upper_zero_a: assert property (@(posedge clk) disable iff (reset) // [R4]
    1'b1 |->
    rd_data[7:4] == 4'h0)
    else $error("upper bits not zero");
  dir_write_a: assert property (@(posedge clk) disable iff (reset) // [R5]
    wr_strobe && reg_index == pvrb_pkg::idx_pin_direction |=>
    general_io_pins_oe == $past(wr_data[3:0]))
    else $error("direction not set");
  dir_hold_a: assert property (@(posedge clk) disable iff (reset) // [R5]
    !(wr_strobe && reg_index == pvrb_pkg::idx_pin_direction) |=>
    $stable(general_io_pins_oe))
    else $error("direction changed without a write");
  reset_clear_a: assert property (@(posedge clk) // [R5]
    reset |=>
    general_io_pins_oe == 4'h0 && rd_data == pvrb_pkg::reset_byte && !nv_cmd.valid)
    else $error("outputs not cleared by reset");

  // Serial memory staging and commands
  select_latch_a: assert property (@(posedge clk) disable iff (reset) // [R6]
    wr_strobe && reg_index == pvrb_pkg::idx_write_enable_select |=>
    enable_select == $past(wr_data[0]))
    else $error("write enable select not stored");
  word_low_a: assert property (@(posedge clk) disable iff (reset) // [R8]
    wr_strobe && reg_index == pvrb_pkg::idx_word_low |=>
    word_low == $past(wr_data))
    else $error("low word byte not stored");
  word_high_a: assert property (@(posedge clk) disable iff (reset) // [R9]
    wr_strobe && reg_index == pvrb_pkg::idx_word_high |=>
    word_high == $past(wr_data))
    else $error("high word byte not stored");
  ena_cmd_a: assert property (@(posedge clk) disable iff (reset) // [R11]
    cmd_enable_seq |=>
    nv_cmd.valid && !nv_cmd.is_write && nv_cmd.enable == $past(enable_select))
    else $error("enable command wrong");
  word_cmd_a: assert property (@(posedge clk) disable iff (reset) // [R12]
    cmd_write_seq |=>
    nv_cmd.valid && nv_cmd.is_write && nv_cmd.word == {$past(word_high), $past(word_low)})
    else $error("write word wrong");
  bad_code_a: assert property (@(posedge clk) disable iff (reset) // [R11]
    cmd_accept && wr_data != pvrb_pkg::cmd_enable_disable &&
    wr_data != pvrb_pkg::cmd_write_word |=> !nv_cmd.valid)
    else $error("unknown command code taken");
  no_spurious_a: assert property (@(posedge clk) disable iff (reset) // [R12]
    cmd_idle_seq |=>
    !nv_cmd.valid)
    else $error("command raised without a write");
  busy_hold_a: assert property (@(posedge clk) disable iff (reset) // [R19]
    cmd_held_seq |=>
    nv_cmd.valid && $stable(nv_cmd))
    else $error("command changed while busy");
  cmd_refuse_a: assert property (@(posedge clk) disable iff (reset) // [R19]
    cmd_refused_seq |=>
    $stable(nv_cmd.word) && $stable(nv_cmd.is_write) && $stable(nv_cmd.enable))
    else $error("command write taken while busy");
  cmd_release_a: assert property (@(posedge clk) disable iff (reset) // [R19]
    cmd_done_seq |=>
    !nv_cmd.valid)
    else $error("command not released on done");

  // Window sizes and I/O selects
  window_load_a: assert property (@(posedge clk) disable iff (reset) // [R16]
    nv_load.load && nv_load.addr == pvrb_pkg::nv_addr_window_zero |=>
    window_zero == $past(nv_load.data[1:0]))
    else $error("window zero not loaded");
  window_hold_a: assert property (@(posedge clk) disable iff (reset) // [R16]
    !(nv_load.load && nv_load.addr == pvrb_pkg::nv_addr_window_zero) |=>
    $stable(window_zero))
    else $error("window zero changed without a load");
  window_one_a: assert property (@(posedge clk) disable iff (reset) // [R16]
    nv_load.load && nv_load.addr == pvrb_pkg::nv_addr_window_one |=>
    window_one == $past(nv_load.data[1:0]))
    else $error("window one not loaded");
  window_keep_a: assert property (@(posedge clk) disable iff (reset) // [R16]
    !(nv_load.load && nv_load.addr == pvrb_pkg::nv_addr_window_one) |=>
    $stable(window_one))
    else $error("window one changed without a load");
  sel_valid_a: assert property (@(posedge clk) disable iff (reset) // [R18]
    io_select_zero || io_select_one |->
    $past(io_valid))
    else $error("select without an I/O cycle");
  sel_block_a: assert property (@(posedge clk) disable iff (reset) // [R18]
    io_select_zero |->
    $past(io_addr[15:7]) == $past(io_base_zero[15:7]))
    else $error("select zero outside its block");
  sel_one_a: assert property (@(posedge clk) disable iff (reset) // [R18]
    io_select_one |->
    $past(io_addr[15:7]) == $past(io_base_one[15:7]))
    else $error("select one outside its block");
  sel_size_a: assert property (@(posedge clk) disable iff (reset) // [R15]
    io_select_zero && $past(window_zero) == 2'h0 |->
    $past(io_addr[15:4]) == $past(io_base_zero[15:4]))
    else $error("smallest window too wide");

  // State readback
  state_read_a: assert property (@(posedge clk) disable iff (reset) // [R10]
    reg_index == pvrb_pkg::idx_state_readback |=>
    $onehot(rd_data[3:0]))
    else $error("state not one-hot");
  state_exact_a: assert property (@(posedge clk) disable iff (reset) // [R10]
    reg_index == pvrb_pkg::idx_state_readback |=>
    rd_data == {4'h0, $past(cfg_state)})
    else $error("state readback wrong");
endmodule

//--- rtl/pvrb_pkg.sv
/*
  Constants and carrier types for the vendor register bank.
  Assumes the surrounding controller decodes the auto-configuration ports.
*/
// Function
// (R1) An output pin follows the written data bit, one high, zero low.
// (R2) Data written for input pins does not affect those pins.
// (R3) Reading pin data returns sampled pin levels whatever the direction.
// (R4) Upper four bits of pin data, direction and state read zero.
// (R5) Direction bit one makes the pin an output, zero an input.
// (R6) Write-enable bit zero picks enable or disable for the next command.
// (R7) Write protection persists until another enable or disable command.
// (R8) Low data register holds the low byte of the next written word.
// (R9) High data register holds the high byte of the next written word.
// (R10) State readback is one-hot: wait key, sleep, isolation, configuration.
// (R11) Command value zero sends enable or disable as the select bit says.
// (R12) Command value one starts a write of the high and low word.
// (R13) Host sets the write-enable select before the enable/disable command.
// (R14) Host write-enables the memory before issuing the write command.
// (R15) Window size code 00..11 means 16, 32, 64, 128 bytes.
// (R16) Window sizes are internal, loaded at reset from bytes 0x010 and 0x011.
// (R17) Registers are reached through index, write-data and read-data ports.
// (R18) Each I/O select asserts only inside base plus window size; the code rounds an unaligned base down to a multiple of the window size.
// (R19) Command writes are ignored while a serial command is in progress.
package pvrb_pkg;
  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [7:0] idx_pin_data = 8'h20;
  localparam logic [7:0] idx_pin_direction = 8'h21;
  localparam logic [7:0] idx_write_enable_select = 8'h22;
  localparam logic [7:0] idx_word_low = 8'h23;
  localparam logic [7:0] idx_word_high = 8'h24;
  localparam logic [7:0] idx_state_readback = 8'h25;
  localparam logic [7:0] idx_command_trigger = 8'h26;
  // ------------------------------------------------------------
  // Field values and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] cmd_enable_disable = 8'h00;
  localparam logic [7:0] cmd_write_word = 8'h01;
  localparam logic [3:0] reset_nibble = 4'h0;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [1:0] reset_window = 2'h0;
  localparam logic [10:0] nv_addr_window_zero = 11'h010;
  localparam logic [10:0] nv_addr_window_one = 11'h011;
  localparam int base_window_bits = 4;
  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    pvrb_wait_key = 4'b0001,
    pvrb_sleep = 4'b0010,
    pvrb_isolation = 4'b0100,
    pvrb_config = 4'b1000
  } pvrb_cfg_state_e;
  typedef struct packed {
    logic valid;
    logic is_write;
    logic enable;
    logic [15:0] word;
  } pvrb_nv_cmd_s;
  typedef struct packed {
    logic load;
    logic [10:0] addr;
    logic [7:0] data;
  } pvrb_nv_load_s;
endpackage

//--- verification/pvrb_nv_partner.sv
/*
  Serial memory model behind the register bank's command port.
  Assumes commands arrive as a level that holds until the done pulse.
*/
`timescale 1ns/1ns
module pvrb_nv_partner #(
  parameter int done_delay = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire pvrb_pkg::pvrb_nv_cmd_s nv_cmd,
  output logic nv_cmd_done,
  output logic write_enabled,
  output logic [15:0] stored_word
);
  int cnt;
  // Slow answer on purpose, so that refused commands land while busy
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 0;
      nv_cmd_done <= 1'b0;
      write_enabled <= 1'b0;
      stored_word <= 16'h0000;
    end else if (nv_cmd_done) begin
      nv_cmd_done <= 1'b0;
      cnt <= 0;
    end else if (nv_cmd.valid) begin
      cnt <= cnt + 1;
      if (cnt == done_delay) begin
        nv_cmd_done <= 1'b1;
        if (!nv_cmd.is_write) begin
          write_enabled <= nv_cmd.enable;
        end else if (write_enabled) begin
          stored_word <= nv_cmd.word;
        end
      end
    end
  end
endmodule

//--- verification/pvrb_register_bank_tb.sv
/*
  Self-checking bench for the vendor register bank.
  Assumes the serial memory model answers every command.
*/
`timescale 1ns/1ns
module pvrb_register_bank_tb;
  logic clk, reset, wr_strobe, nv_cmd_done, nv_busy, io_valid, sel0, sel1, nv_en;
  logic [7:0] reg_index, wr_data, rd_data, v;
  logic [3:0] pins_ext, pins_in, pins_out, pins_oe;
  logic [15:0] io_addr, base0, base1, nv_word;
  pvrb_pkg::pvrb_cfg_state_e cfg_state;
  pvrb_pkg::pvrb_nv_cmd_s nv_cmd;
  pvrb_pkg::pvrb_nv_load_s nv_load;
  int error_cnt = 0;
  int compares = 0;
  // Pin level: driven value where enabled, else the outside world
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & pins_ext);
  pvrb_register_bank dut (.clk(clk), .reset(reset), .reg_index(reg_index),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data), .cfg_state(cfg_state),
    .general_io_pins_level(pins_in), .general_io_pins_data(pins_out),
    .general_io_pins_oe(pins_oe), .nv_cmd(nv_cmd), .nv_cmd_done(nv_cmd_done),
    .nv_busy(nv_busy), .nv_load(nv_load), .io_valid(io_valid), .io_addr(io_addr),
    .io_base_zero(base0), .io_base_one(base1), .io_select_zero(sel0), .io_select_one(sel1));
  pvrb_nv_partner #(.done_delay(5)) mem (.clk(clk), .reset(reset), .nv_cmd(nv_cmd),
    .nv_cmd_done(nv_cmd_done), .write_enabled(nv_en), .stored_word(nv_word));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk) begin reg_index = i; wr_data = d; wr_strobe = 1'b1; end
    @(negedge clk) wr_strobe = 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    @(negedge clk) reg_index = i;
    @(negedge clk) d = rd_data;
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 50 && nv_busy !== 1'b0; n++) @(negedge clk);
    chk(nv_busy, 1'b0);
  endtask
  task automatic probe(input logic [15:0] a, input logic [1:0] e);
    @(negedge clk) begin io_valid = 1'b1; io_addr = a; end
    @(negedge clk) chk({sel0, sel1}, e);
    io_valid = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_pins();
    pins_ext = 4'ha;
    wr(8'h21, 8'hf5);
    wr(8'h20, 8'hfa);
    rd(8'h21, v);
    chk(v, 8'h05);
    chk(pins_oe, 4'h5);
    rd(8'h20, v);
    chk(v, 8'h0a);
    pins_ext = 4'h0;
    rd(8'h20, v);
    chk(v, 8'h00);
    wr(8'h20, 8'h05);
    rd(8'h20, v);
    chk(v, 8'h05);
    $display("test_pins done");
  endtask
  task automatic test_state();
    wr(8'h25, 8'hff);
    for (int i = 0; i < 4; i++) begin
      cfg_state = pvrb_pkg::pvrb_cfg_state_e'(4'h1 << i);
      rd(8'h25, v);
      chk(v, {4'h0, 4'h1 << i});
    end
    $display("test_state done");
  endtask
  task automatic test_nv();
    wr(8'h22, 8'h01);
    wr(8'h26, 8'h00);
    chk({nv_cmd.valid, nv_cmd.is_write, nv_cmd.enable}, 3'b101);
    wait_idle();
    chk(nv_en, 1'b1);
    wr(8'h23, 8'h34);
    wr(8'h24, 8'h12);
    wr(8'h26, 8'h01);
    chk({nv_cmd.valid, nv_cmd.is_write, nv_cmd.word}, {2'b11, 16'h1234});
    wr(8'h22, 8'h00);
    wr(8'h26, 8'h00);
    wait_idle();
    chk(nv_word, 16'h1234);
    @(negedge clk) chk({nv_busy, nv_en}, 2'b01);
    wr(8'h26, 8'h02);
    chk(nv_busy, 1'b0);
    wr(8'h26, 8'h00);
    chk({nv_cmd.valid, nv_cmd.is_write, nv_cmd.enable}, 3'b100);
    wait_idle();
    chk(nv_en, 1'b0);
    $display("test_nv done");
  endtask
  task automatic test_window();
    @(negedge clk) nv_load = {1'b1, 11'h010, 8'h01};
    @(negedge clk) nv_load = {1'b1, 11'h011, 8'h03};
    @(negedge clk) nv_load = '0;
    probe(16'h031f, 2'b10);
    probe(16'h0320, 2'b00);
    probe(16'h02ff, 2'b00);
    probe(16'h047f, 2'b01);
    probe(16'h0480, 2'b00);
    $display("test_window done");
  endtask
  task automatic test_reset();
    wr(8'h21, 8'h0f);
    @(negedge clk) reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    chk({pins_oe, pins_out, nv_busy, sel0, sel1}, 11'h000);
    rd(8'h21, v);
    chk(v, 8'h00);
    probe(16'h030f, 2'b10);
    probe(16'h0310, 2'b00);
    @(negedge clk) nv_load = {1'b1, 11'h012, 8'h03};
    @(negedge clk) nv_load = {1'b1, 11'h010, 8'h02};
    @(negedge clk) nv_load = '0;
    probe(16'h033f, 2'b10);
    probe(16'h0340, 2'b00);
    probe(16'h040f, 2'b01);
    probe(16'h0410, 2'b00);
    $display("test_reset done");
  endtask
  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    {wr_strobe, io_valid, reg_index, wr_data, pins_ext, io_addr} = '0;
    reset = 1'b1;
    cfg_state = pvrb_pkg::pvrb_wait_key;
    nv_load = '0;
    base0 = 16'h0300;
    base1 = 16'h0400;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    test_window();
    test_pins();
    test_state();
    test_nv();
    test_reset();
    finish_test();
  end
endmodule
